/* File: hw/nibble_alu.v */
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "nibble_alu_regs.vh"

module nibble_alu #(
  parameter PAGE_W = 7
) (
  // clock and reset
  input  wire              sys_clk,
  input  wire              rst_b,
  // instruction issue
  input  wire              opValid,
  input  wire [3:0]        opSel,
  input  wire [3:0]        immData,
  input  wire [1:0]        bitSel,
  input  wire [PAGE_W-1:0] tablePage,
  input  wire              upperTableFlag,
  output wire              opReady,
  output reg               opDone,
  output reg               skipNext,
  // pointed data nibble
  input  wire [3:0]        pointedDataNibble,
  output reg               memWrEn,
  output reg  [3:0]        memWrData,
  // return stack use
  output reg               stackBusy,
  // table memory load port
  input  wire              romWrEn,
  input  wire [PAGE_W+6:0] romWrAddr,
  input  wire [9:0]        romWrData,
  // architectural state
  output reg  [3:0]        accReg,
  output reg  [3:0]        upperReg,
  output reg               carryFlagReg,
  output reg  [2:0]        tablePtrReg
);
  // ****************************************
  // state
  // ****************************************
  localparam ST_IDLE = 1'b0;
  localparam ST_TBL  = 1'b1;

  reg        state_reg;
  reg [1:0]  waitCnt_reg;
  reg        lastWasLoad_reg;
  reg        tblUpper_reg;

  wire [9:0] romData;
  wire [PAGE_W+6:0] romAddr;

  // 4-bit add returning carry-out in bit 4
  function [4:0] add4;
    input [3:0] a;
    input [3:0] b;
    input       cin;
    begin
      add4 = {1'b0, a} + {1'b0, b} + {4'h0, cin};
    end
  endfunction

  assign romAddr = {tablePage, tablePtrReg, accReg};
  assign opReady = (state_reg == ST_IDLE);

  table_rom #(
    .ADDR_W (PAGE_W + 7),
    .DATA_W (10)
  ) uRom (
    .sys_clk (sys_clk),
    .rdAddr  (romAddr),
    .rdData  (romData),
    .wrEn    (romWrEn),
    .wrAddr  (romWrAddr),
    .wrData  (romWrData)
  );

  // ****************************************
  // helper functions
  // ****************************************
  // one-hot select of a data nibble bit
  function [3:0] bit_mask;
    input [1:0] sel;
    begin
      bit_mask = 4'h1 << sel;
    end
  endfunction

  // rotate right through carry: {new carry, new accumulator}
  function [4:0] rot_carry;
    input [3:0] a;
    input       cin;
    begin
      rot_carry = {a[0], cin, a[3:1]};
    end
  endfunction

  // upper nibble of a table word
  function [3:0] tbl_upper;
    input [9:0] word;
    begin
      tbl_upper = word[`ROM_UPPER_HI:`ROM_UPPER_LO];
    end
  endfunction

  // lower nibble of a table word
  function [3:0] tbl_low;
    input [9:0] word;
    begin
      tbl_low = word[`ROM_LOW_HI:0];
    end
  endfunction

  // new pointer from the extension bits, top pointer bit cleared
  function [2:0] tbl_ptr;
    input [9:0] word;
    begin
      tbl_ptr = {1'b0, word[`ROM_EXT_HI:`ROM_EXT_LO]};
    end
  endfunction

  // skip request for the instruction after a conditional op
  function skip_cond;
    input [3:0] op;
    input       sumCarry;
    input       cy;
    input       testBit;
    begin
      case (op)
        `OP_ADD_IMM:  skip_cond = ~sumCarry;
        `OP_SKIP_CY0: skip_cond = ~cy;
        `OP_BIT_TEST: skip_cond = ~testBit;
        default:      skip_cond = 1'b0;
      endcase
    end
  endfunction

  // ****************************************
  // operands
  // ****************************************
  // one shared adder; the op code picks its second operand and carry-in
  reg [4:0] sum;
  reg [3:0] bitMask;
  reg [4:0] rotated;
  reg       testBit;

  always @* begin
    bitMask = bit_mask(bitSel);
    rotated = rot_carry(accReg, carryFlagReg);
    testBit = |(pointedDataNibble & bitMask);
    case (opSel)
      `OP_MEM_ADD_CY: sum = add4(accReg, pointedDataNibble, carryFlagReg);
      `OP_ADD_IMM:    sum = add4(accReg, immData, 1'b0);
      default:        sum = add4(accReg, pointedDataNibble, 1'b0);
    endcase
  end

  // ****************************************
  // next-value logic
  // ****************************************
  reg       state_next;
  reg [1:0] waitCnt_next;
  reg       lastWasLoad_next;
  reg       tblUpper_next;
  reg [3:0] acc_next;
  reg [3:0] upper_next;
  reg       carry_next;
  reg [2:0] tablePtr_next;
  reg       opDone_next;
  reg       skip_next;
  reg       memWrEn_next;
  reg [3:0] memWrData_next;
  reg       stackBusy_next;

  // opValid is ignored while a table read runs; the caller must hold
  // the op until opReady, there is no queue behind the port
  always @* begin
    // hold every state unless an op says otherwise; pulses fall to zero
    state_next       = state_reg;
    waitCnt_next     = waitCnt_reg;
    lastWasLoad_next = lastWasLoad_reg;
    tblUpper_next    = tblUpper_reg;
    acc_next         = accReg;
    upper_next       = upperReg;
    carry_next       = carryFlagReg;
    tablePtr_next    = tablePtrReg;
    opDone_next      = 1'b0;
    skip_next        = 1'b0;
    memWrEn_next     = 1'b0;
    // the caller stores memWrData only while memWrEn is high
    memWrData_next   = memWrData;
    stackBusy_next   = stackBusy;
    case (state_reg)
      ST_IDLE: begin
        if (opValid) begin
          // any non-load instruction ends a run of loads
          lastWasLoad_next = (opSel == `OP_LOAD_IMM);
          skip_next = skip_cond(opSel, sum[4], carryFlagReg, testBit);
          if (opSel == `OP_TABLE_READ) begin
            state_next     = ST_TBL;
            waitCnt_next   = `TABLE_WAIT_CYCLES;
            tblUpper_next  = upperTableFlag;
            stackBusy_next = 1'b1;
          end else begin
            opDone_next = 1'b1;
          end
          case (opSel)
            `OP_LOAD_IMM: begin
              if (!lastWasLoad_reg) begin
                acc_next = immData;
              end
            end
            `OP_MEM_ADD: begin
              acc_next = sum[3:0];
            end
            `OP_MEM_ADD_CY: begin
              acc_next   = sum[3:0];
              carry_next = sum[4];
            end
            `OP_ADD_IMM: begin
              acc_next = sum[3:0];
            end
            `OP_AND: begin
              acc_next = accReg & pointedDataNibble;
            end
            `OP_OR: begin
              acc_next = accReg | pointedDataNibble;
            end
            `OP_CARRY_SET: begin
              carry_next = 1'b1;
            end
            `OP_CARRY_CLR: begin
              carry_next = 1'b0;
            end
            `OP_SKIP_CY0: begin
              // carry flag left alone, only the skip is raised
            end
            `OP_COMPLEMENT: begin
              acc_next = ~accReg;
            end
            `OP_ROTATE_R: begin
              acc_next   = rotated[3:0];
              carry_next = rotated[4];
            end
            `OP_BIT_SET: begin
              memWrEn_next   = 1'b1;
              memWrData_next = pointedDataNibble | bitMask;
            end
            `OP_BIT_CLR: begin
              memWrEn_next   = 1'b1;
              memWrData_next = pointedDataNibble & ~bitMask;
            end
            `OP_BIT_TEST: begin
              // the data nibble is only read, the skip is raised above
            end
            default: begin
            end
          endcase
        end
      end
      ST_TBL: begin
        // one cycle for the address, one for registered read data
        waitCnt_next = waitCnt_reg - 2'h1;
        if (waitCnt_reg == 2'h1) begin
          upper_next = tbl_upper(romData);
          acc_next   = tbl_low(romData);
          // the upper flag is the one captured when the read was taken
          if (tblUpper_reg) begin
            tablePtr_next = tbl_ptr(romData);
          end
          stackBusy_next = 1'b0;
          opDone_next    = 1'b1;
          state_next     = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // ****************************************
  // registers
  // ****************************************
  // registers only; every decision is made in the next-value logic
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg       <= ST_IDLE;
      waitCnt_reg     <= 2'h0;
      lastWasLoad_reg <= 1'b0;
      tblUpper_reg    <= 1'b0;
      opDone          <= 1'b0;
      skipNext        <= 1'b0;
      memWrEn         <= 1'b0;
      memWrData       <= 4'h0;
      stackBusy       <= 1'b0;
      accReg          <= `ACC_RESET;
      upperReg        <= `UPPER_RESET;
      carryFlagReg    <= `CARRY_RESET;
      tablePtrReg     <= `TPTR_RESET;
    end else begin
      state_reg       <= state_next;
      waitCnt_reg     <= waitCnt_next;
      lastWasLoad_reg <= lastWasLoad_next;
      tblUpper_reg    <= tblUpper_next;
      opDone          <= opDone_next;
      skipNext        <= skip_next;
      memWrEn         <= memWrEn_next;
      memWrData       <= memWrData_next;
      stackBusy       <= stackBusy_next;
      accReg          <= acc_next;
      upperReg        <= upper_next;
      carryFlagReg    <= carry_next;
      tablePtrReg     <= tablePtr_next;
    end
  end
endmodule

/* File: hw/nibble_alu_regs.vh */
`ifndef NIBBLE_ALU_REGS_VH
`define NIBBLE_ALU_REGS_VH
// ****************************************
// operation codes presented on opSel
// ****************************************
`define OP_NONE        4'h0
`define OP_LOAD_IMM    4'h1
`define OP_TABLE_READ  4'h2
`define OP_MEM_ADD     4'h3
`define OP_MEM_ADD_CY  4'h4
`define OP_ADD_IMM     4'h5
`define OP_AND         4'h6
`define OP_OR          4'h7
`define OP_CARRY_SET   4'h8
`define OP_CARRY_CLR   4'h9
`define OP_SKIP_CY0    4'ha
`define OP_COMPLEMENT  4'hb
`define OP_ROTATE_R    4'hc
`define OP_BIT_SET     4'hd
`define OP_BIT_CLR     4'he
`define OP_BIT_TEST    4'hf
// ****************************************
// reset values and field positions
// ****************************************
`define ACC_RESET      4'h0
`define UPPER_RESET    4'h0
`define CARRY_RESET    1'b0
`define TPTR_RESET     3'h0
`define ROM_UPPER_HI   7
`define ROM_UPPER_LO   4
`define ROM_LOW_HI     3
`define ROM_EXT_HI     9
`define ROM_EXT_LO     8
// ****************************************
// timing
// ****************************************
`define TABLE_WAIT_CYCLES 2'h2
`endif

/* File: hw/table_rom.v */
`timescale 1ns/1ps
// ****************************************
// small program-memory table, registered read
// ****************************************
module table_rom #(
  parameter ADDR_W = 7,
  parameter DATA_W = 10
) (
  // clock
  input  wire              sys_clk,
  // read port
  input  wire [ADDR_W-1:0] rdAddr,
  output reg  [DATA_W-1:0] rdData,
  // load port
  input  wire              wrEn,
  input  wire [ADDR_W-1:0] wrAddr,
  input  wire [DATA_W-1:0] wrData
);
  reg [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  always @(posedge sys_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule

/* File: verification/nibble_alu_properties.sv */
`timescale 1ns/1ps
`include "nibble_alu_regs.vh"
// ****************************************
// datapath checker
// ****************************************
module nibble_alu_checker (
  // clock and reset
  input logic       sys_clk,
  input logic       rst_b,
  // issue side
  input logic       opValid,
  input logic [3:0] opSel,
  input logic [3:0] immData,
  input logic [1:0] bitSel,
  input logic [3:0] pointedDataNibble,
  // results
  input logic       opReady,
  input logic       opDone,
  input logic       skipNext,
  input logic       memWrEn,
  input logic [3:0] memWrData,
  input logic       stackBusy,
  input logic [3:0] accReg,
  input logic       carryFlagReg
);
  wire go = opValid && opReady;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  chk_add_imm_sum: assert property (
    go && opSel == `OP_ADD_IMM |=> accReg == $past(accReg) + $past(immData)
    && $stable(carryFlagReg)) else $error("add immediate sum wrong");
  chk_add_imm_skip: assert property (
    go && opSel == `OP_ADD_IMM |=> skipNext ==
    ({1'b0, $past(accReg)} + {1'b0, $past(immData)} < 5'h10))
    else $error("add immediate skip wrong");
  chk_carry_set_clr: assert property (
    go && opSel[3:1] == 3'h4 |=> carryFlagReg == !$past(opSel[0]))
    else $error("carry set or clear wrong");
  chk_skip_carry: assert property (
    go && opSel == `OP_SKIP_CY0 |=> skipNext == !$past(carryFlagReg)
    && $stable(carryFlagReg)) else $error("carry skip wrong");
  chk_complement_acc: assert property (
    go && opSel == `OP_COMPLEMENT |=> accReg == ~$past(accReg))
    else $error("complement wrong");
  chk_rotate_chain: assert property (
    go && opSel == `OP_ROTATE_R |=> {accReg, carryFlagReg} ==
    {$past(carryFlagReg), $past(accReg)}) else $error("rotate wrong");
  chk_bit_write: assert property (
    go && opSel == `OP_BIT_SET |=> memWrEn && memWrData ==
    ($past(pointedDataNibble) | 4'h1 << $past(bitSel)))
    else $error("bit set wrong");
  chk_bit_clear: assert property (
    go && opSel == `OP_BIT_CLR |=> memWrEn && memWrData ==
    ($past(pointedDataNibble) & ~(4'h1 << $past(bitSel))))
    else $error("bit clear wrong");
  chk_bit_test_skip: assert property (
    go && opSel == `OP_BIT_TEST |=> skipNext ==
    !(|($past(pointedDataNibble) & 4'h1 << $past(bitSel))))
    else $error("bit test skip wrong");
  chk_table_stack: assert property (
    go && opSel == `OP_TABLE_READ |=> (stackBusy && !opReady) [*2]
    ##1 (opDone && !stackBusy)) else $error("table read timing wrong");
  cover property (go && opSel == `OP_TABLE_READ);
  cover property (skipNext);
  cover property (go && opSel == `OP_LOAD_IMM ##2 opSel == `OP_LOAD_IMM);
endmodule
bind nibble_alu nibble_alu_checker i_chk (.*);

/* File: verification/testbench.sv */
`timescale 1ns/1ps
`include "nibble_alu_regs.vh"
module testbench;
  logic       sys_clk = 0, rst_b = 0, opValid = 0;
  logic       upperTableFlag = 0, romWrEn = 0;
  logic [3:0] opSel = 0, immData = 0, pointedDataNibble = 0;
  logic [1:0] bitSel = 0;
  logic [6:0] tablePage = 0;
  logic [13:0] romWrAddr = 0;
  logic [9:0] romWrData = 0;
  wire        opReady, opDone, skipNext, memWrEn, stackBusy, carryFlagReg;
  wire [3:0]  memWrData, accReg, upperReg;
  wire [2:0]  tablePtrReg;
  int errors = 0, check_count = 0, a = 0, c = 0, ll = 0, m, i, j, s, sk, k;
  nibble_alu i_dut (.*);
  initial forever #12.5 sys_clk = ~sys_clk;
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wrap_up;
    $display("checks=%0d errors=%0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // one op with a gap cycle after it, then model against design
  task issue(input int op);
    @(posedge sys_clk);
    i = $urandom % 16;
    m = $urandom % 16;
    j = $urandom % 4;
    opValid <= 1;
    opSel <= op[3:0];
    immData <= i[3:0];
    pointedDataNibble <= m[3:0];
    bitSel <= j[1:0];
    @(posedge sys_clk);
    opValid <= 0;
    @(negedge sys_clk);
    sk = 0;
    case (op)
      1: if (!ll) a = i;
      3: a = (a + m) % 16;
      4: begin s = a + m + c; a = s % 16; c = s / 16; end
      5: begin s = a + i; a = s % 16; sk = s < 16; end
      6: a = a & m;
      7: a = a | m;
      8: c = 1;
      9: c = 0;
      10: sk = !c;
      11: a = ~a & 15;
      12: begin s = c * 8 + a / 2; c = a % 2; a = s; end
      13: chk({memWrEn, memWrData}, 16 | m | 1 << j);
      14: chk({memWrEn, memWrData}, 16 | m & ~(1 << j) & 15);
      15: sk = !(m >> j & 1);
    endcase
    ll = (op == 1);
    chk(accReg, a);
    chk(carryFlagReg, c);
    chk(skipNext, sk);
    chk(opDone, 1);
  endtask
  initial begin
    void'($urandom(59232));
    repeat (5) @(posedge sys_clk);
    rst_b <= 1;
    issue(1);
    issue(1);
    // ****************************************
    // table read with the upper flag set
    // ****************************************
    @(posedge sys_clk);
    romWrEn <= 1;
    romWrAddr <= {7'h0, 3'h0, 4'(a)};
    romWrData <= 10'h2a5;
    upperTableFlag <= 1;
    @(posedge sys_clk);
    romWrEn <= 0;
    opValid <= 1;
    opSel <= `OP_TABLE_READ;
    @(posedge sys_clk);
    opValid <= 0;
    @(negedge sys_clk);
    chk({stackBusy, opReady}, 2);
    for (k = 0; k < 8 && !opDone; k++) @(negedge sys_clk);
    if (opDone !== 1'b1) begin
      errors++;
      wrap_up;
    end
    chk(upperReg, 4'ha);
    chk(accReg, 4'h5);
    chk(tablePtrReg, 3'h2);
    a = 5;
    ll = 0;
    repeat (400) begin
      k = 1 + $urandom % 15;
      issue(k == 2 ? 1 : k);
    end
    wrap_up;
  end
endmodule
